// File: core/ifv_irq_ctrl.sv
// Interrupt request flags, vectoring to the core and the time base generator.
`timescale 1ns/1ps
`default_nettype none
`include "ifv_consts.svh"
module ifv_irq_ctrl #(
   // Ticks of the shortest time base period; lower it to speed up a simulation.
   parameter int TB_BASE = `IFV_TB_BASE
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hall_in_a,
   input wire logic hall_in_b,
   input wire logic hall_in_c,
   input wire logic ext1_pin,
   input wire logic ext1_pull_sel,
   output logic ext1_pull_en,
   input wire logic cmp0_out,
   input wire logic tbase_src_clk,
   input wire logic tmr2_match_a,
   input wire logic tmr2_match_p,
   input wire logic stack_full,
   input wire logic instr_boundary,
   input wire logic return_from_irq,
   output logic irq_req,
   output logic stack_push,
   output logic pc_load,
   output logic [7:0] pc_vector,
   output logic stack_pop,
   output logic wake_req
);
   import ifv_pkg::*;

   // Shortest period as a 16-bit figure, so the shifted value cannot overflow.
   localparam logic [15:0] TB_BASE16 = 16'(TB_BASE);

   // Current and next state of the whole block.
   ifv_state_t s;
   ifv_state_t next_s;
   // Edge events: Hall a, b, c, external pin, comparator, time base clock.
   logic [`IFV_EDGE_N-1:0] evt;
   // Edge codes for the six detector lanes.
   logic [2*`IFV_EDGE_N-1:0] edge_sel;
   // Enabled, flagged sources in priority order.
   logic [`IFV_NSRC-1:0] pend;
   // Index of the winning source.
   logic [2:0] win;
   // Accept strobe: request standing at an instruction boundary.
   logic take;
   // Decoded APB phases.
   logic wr;
   logic rd_setup;
   // Address hits a mapped register.
   logic mapped;
   // Read value of the addressed register.
   logic [31:0] rdata;
   // Divider terminal count for the selected period.
   logic [14:0] tb_term;
   // One divider input tick.
   logic tb_tick;
   // All flags packed, before and after this cycle, for the wake detector.
   logic [9:0] flags_now;
   logic [9:0] flags_next;

   // The comparator toggles on either edge; the time base counts rising edges.
   assign edge_sel = {`IFV_EDGE_RISE, `IFV_EDGE_BOTH, s.ext1_edge_sel, s.hall_edge_sel};

   // Synchronise every asynchronous event input and detect its edges.
   ifv_edge_det u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin({tbase_src_clk, cmp0_out, ext1_pin, hall_in_c, hall_in_b, hall_in_a}),
      .sel(edge_sel),
      .evt(evt)
   );

   // The pull-high choice passes straight to the pad in every pin mode.
   assign ext1_pull_en = ext1_pull_sel;

   // Sources that may vector, index 0 first.
   always_comb begin
      pend[0] = s.hall_group_flag & s.hall_group_en;
      pend[1] = s.ext1_flag & s.ext1_en;
      pend[2] = s.cmp0_flag & s.cmp0_en;
      pend[3] = s.tbase_flag & s.tbase_en;
      pend[4] = s.multifunc_group_flag & s.multifunc_group_en;
   end

   // Lowest index wins; the loop runs downward so the last hit is the lowest.
   always_comb begin
      win = 3'h0;
      for (int k = `IFV_NSRC - 1; k >= 0; k--) begin
         if (pend[k]) begin
            win = 3'(k);
         end
      end
   end

   // Request only with the global enable high and room on the stack.
   assign irq_req = s.global_irq_enable & ~stack_full & (|pend);
   // The core takes the request at the next instruction boundary.
   assign take = irq_req & instr_boundary;

   // APB decode; the slave never stalls, so pready is constant high.
   assign wr = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Divider end value is the chosen period minus one.
   assign tb_term = 15'((TB_BASE16 << s.tbase_period_sel) - 16'h1);
   // Tick from the quarter-rate prescaler or the dedicated clock's rising edge.
   assign tb_tick = s.tbase_clk_sel ? (s.pre == `IFV_PRE_LAST) : evt[`IFV_LANE_TBCLK];

   // Read multiplexer; unused bits read as zero.
   always_comb begin
      rdata = 32'h0;
      mapped = 1'b1;
      case (paddr)
         `IFV_OFF_CTRL0: begin
            rdata[`IFV_B_GLOBAL_EN] = s.global_irq_enable;
            rdata[`IFV_B_HALL_GRP_EN] = s.hall_group_en;
            rdata[`IFV_B_EXT1_EN] = s.ext1_en;
            rdata[`IFV_B_CMP0_EN] = s.cmp0_en;
            rdata[`IFV_B_HALL_GRP_FLAG] = s.hall_group_flag;
            rdata[`IFV_B_EXT1_FLAG] = s.ext1_flag;
            rdata[`IFV_B_CMP0_FLAG] = s.cmp0_flag;
         end
         `IFV_OFF_CTRL1: begin
            rdata[`IFV_B_TBASE_EN] = s.tbase_en;
            rdata[`IFV_B_MF_EN] = s.multifunc_group_en;
            rdata[`IFV_B_TBASE_FLAG] = s.tbase_flag;
            rdata[`IFV_B_MF_FLAG] = s.multifunc_group_flag;
         end
         `IFV_OFF_HALL: begin
            rdata[`IFV_B_HALL_EN +: 3] = s.hall_en;
            rdata[`IFV_B_HALL_FLAG +: 3] = s.hall_flag;
            rdata[`IFV_B_HALL_EDGE +: 6] = s.hall_edge_sel;
            rdata[`IFV_B_EXT1_EDGE +: 2] = s.ext1_edge_sel;
         end
         `IFV_OFF_TMR2: begin
            // Bits 7 to 6 and 3 to 2 stay zero from the default above.
            rdata[`IFV_B_T2P_EN] = s.tmr2_match_p_en;
            rdata[`IFV_B_T2A_EN] = s.tmr2_match_a_en;
            rdata[`IFV_B_T2P_FLAG] = s.tmr2_match_p_flag;
            rdata[`IFV_B_T2A_FLAG] = s.tmr2_match_a_flag;
         end
         `IFV_OFF_TBASE: begin
            rdata[`IFV_B_TB_ON] = s.tbase_on;
            rdata[`IFV_B_TB_CLK_SEL] = s.tbase_clk_sel;
            rdata[`IFV_B_TB_PERIOD +: 2] = s.tbase_period_sel;
         end
         `IFV_OFF_STATUS: begin
            rdata[7:0] = s.vector;
            rdata[`IFV_B_ST_REQ] = irq_req;
            rdata[`IFV_B_ST_FULL] = stack_full;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Pack every flag so the wake logic sees each one's rising transition.
   // Only the current flags live here; the next ones are packed inside the
   // next-state process, so no loop runs between two combinational blocks.
   always_comb begin
      flags_now = {s.hall_group_flag, s.ext1_flag, s.cmp0_flag, s.tbase_flag,
                   s.multifunc_group_flag, s.hall_flag, s.tmr2_match_a_flag,
                   s.tmr2_match_p_flag};
   end

   // Next state. Order matters: software writes first, then the clears of
   // an accepted interrupt, then hardware events, so a hardware set always wins.
   always_comb begin
      next_s = s;
      next_s.push = 1'b0;
      next_s.load = 1'b0;
      next_s.pop = 1'b0;

      // Capture read data in the setup phase so it is a flop in the access phase.
      if (rd_setup) begin
         next_s.prdata = rdata;
      end

      // Register writes; a written one sets a flag, a zero clears it.
      if (wr) begin
         case (paddr)
            `IFV_OFF_CTRL0: begin
               next_s.global_irq_enable = pwdata[`IFV_B_GLOBAL_EN];
               next_s.hall_group_en = pwdata[`IFV_B_HALL_GRP_EN];
               next_s.ext1_en = pwdata[`IFV_B_EXT1_EN];
               next_s.cmp0_en = pwdata[`IFV_B_CMP0_EN];
               next_s.hall_group_flag = pwdata[`IFV_B_HALL_GRP_FLAG];
               next_s.ext1_flag = pwdata[`IFV_B_EXT1_FLAG];
               next_s.cmp0_flag = pwdata[`IFV_B_CMP0_FLAG];
            end
            `IFV_OFF_CTRL1: begin
               next_s.tbase_en = pwdata[`IFV_B_TBASE_EN];
               next_s.multifunc_group_en = pwdata[`IFV_B_MF_EN];
               next_s.tbase_flag = pwdata[`IFV_B_TBASE_FLAG];
               next_s.multifunc_group_flag = pwdata[`IFV_B_MF_FLAG];
            end
            `IFV_OFF_HALL: begin
               next_s.hall_en = pwdata[`IFV_B_HALL_EN +: 3];
               next_s.hall_flag = pwdata[`IFV_B_HALL_FLAG +: 3];
               next_s.hall_edge_sel = pwdata[`IFV_B_HALL_EDGE +: 6];
               next_s.ext1_edge_sel = pwdata[`IFV_B_EXT1_EDGE +: 2];
            end
            `IFV_OFF_TMR2: begin
               next_s.tmr2_match_p_en = pwdata[`IFV_B_T2P_EN];
               next_s.tmr2_match_a_en = pwdata[`IFV_B_T2A_EN];
               next_s.tmr2_match_p_flag = pwdata[`IFV_B_T2P_FLAG];
               next_s.tmr2_match_a_flag = pwdata[`IFV_B_T2A_FLAG];
            end
            `IFV_OFF_TBASE: begin
               next_s.tbase_on = pwdata[`IFV_B_TB_ON];
               next_s.tbase_clk_sel = pwdata[`IFV_B_TB_CLK_SEL];
               next_s.tbase_period_sel = pwdata[`IFV_B_TB_PERIOD +: 2];
            end
            default: begin
               // Status is read-only and other offsets hold nothing.
            end
         endcase
      end

      // Accepting an interrupt: drop the global enable and the winner's flag.
      // Member flags of a group are left for software to clear.
      if (take) begin
         next_s.global_irq_enable = 1'b0;
         next_s.push = 1'b1;
         next_s.load = 1'b1;
         case (win)
            3'h0: begin
               next_s.hall_group_flag = 1'b0;
               next_s.vector = `IFV_VEC_HALL;
            end
            3'h1: begin
               next_s.ext1_flag = 1'b0;
               next_s.vector = `IFV_VEC_EXT1;
            end
            3'h2: begin
               next_s.cmp0_flag = 1'b0;
               next_s.vector = `IFV_VEC_CMP0;
            end
            3'h3: begin
               next_s.tbase_flag = 1'b0;
               next_s.vector = `IFV_VEC_TBASE;
            end
            default: begin
               next_s.multifunc_group_flag = 1'b0;
               next_s.vector = `IFV_VEC_MF;
            end
         endcase
      end

      // Return from an interrupt pops the saved address off the stack.
      if (return_from_irq) begin
         next_s.pop = 1'b1;
      end

      // Hardware events set flags whatever the enables say, except the group flags, which need an enabled member.
      next_s.hall_flag = next_s.hall_flag | evt[2:0];
      if (|(evt[2:0] & s.hall_en)) begin
         next_s.hall_group_flag = 1'b1;
      end
      if (evt[`IFV_LANE_EXT1]) begin
         next_s.ext1_flag = 1'b1;
      end
      if (evt[`IFV_LANE_CMP0]) begin
         next_s.cmp0_flag = 1'b1;
      end
      if (tmr2_match_a) begin
         next_s.tmr2_match_a_flag = 1'b1;
      end
      if (tmr2_match_p) begin
         next_s.tmr2_match_p_flag = 1'b1;
      end
      if ((tmr2_match_a & s.tmr2_match_a_en) | (tmr2_match_p & s.tmr2_match_p_en)) begin
         next_s.multifunc_group_flag = 1'b1;
      end

      // Time base divider; it restarts from zero each time it is switched on.
      if (!s.tbase_on) begin
         next_s.tb_cnt = 15'h0;
         next_s.pre = 2'h0;
      end else begin
         next_s.pre = s.pre + 2'h1;
         if (tb_tick) begin
            if (s.tb_cnt >= tb_term) begin
               next_s.tb_cnt = 15'h0;
               next_s.tbase_flag = 1'b1;
            end else begin
               next_s.tb_cnt = s.tb_cnt + 15'h1;
            end
         end
      end

      // Wake pulse on any flag going from clear to set, software sets included.
      flags_next = {next_s.hall_group_flag, next_s.ext1_flag, next_s.cmp0_flag,
                    next_s.tbase_flag, next_s.multifunc_group_flag, next_s.hall_flag,
                    next_s.tmr2_match_a_flag, next_s.tmr2_match_p_flag};
      next_s.wake = |(flags_next & ~flags_now);
   end

   // Register the whole state; the period field resets to its longest code.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.tbase_period_sel <= `IFV_TB_PERIOD_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state flops.
   assign prdata = s.prdata;
   assign stack_push = s.push;
   assign pc_load = s.load;
   assign pc_vector = s.vector;
   assign stack_pop = s.pop;
   assign wake_req = s.wake;
endmodule // ifv_irq_ctrl
`default_nettype wire

// File: common/ifv_consts.svh
// Constants for the interrupt flag, vectoring and time base block.
`ifndef IFV_CONSTS_SVH
`define IFV_CONSTS_SVH

// Register byte offsets on the APB bus.
`define IFV_OFF_CTRL0 8'h00
`define IFV_OFF_CTRL1 8'h04
`define IFV_OFF_HALL 8'h08
`define IFV_OFF_TMR2 8'h0c
`define IFV_OFF_TBASE 8'h10
`define IFV_OFF_STATUS 8'h14

// Control register 0 field positions.
`define IFV_B_GLOBAL_EN 0
`define IFV_B_HALL_GRP_EN 1
`define IFV_B_EXT1_EN 2
`define IFV_B_CMP0_EN 3
`define IFV_B_HALL_GRP_FLAG 4
`define IFV_B_EXT1_FLAG 5
`define IFV_B_CMP0_FLAG 6

// Control register 1 field positions.
`define IFV_B_TBASE_EN 0
`define IFV_B_MF_EN 1
`define IFV_B_TBASE_FLAG 4
`define IFV_B_MF_FLAG 5

// Hall register field positions.
`define IFV_B_HALL_EN 0
`define IFV_B_HALL_FLAG 4
`define IFV_B_HALL_EDGE 8
`define IFV_B_EXT1_EDGE 14

// Timer-2 register field positions.
`define IFV_B_T2P_EN 0
`define IFV_B_T2A_EN 1
`define IFV_B_T2P_FLAG 4
`define IFV_B_T2A_FLAG 5

// Time base control field positions and reset value.
`define IFV_B_TB_PERIOD 4
`define IFV_B_TB_CLK_SEL 6
`define IFV_B_TB_ON 7
`define IFV_TB_PERIOD_RST 2'h3
`define IFV_TB_BASE 4096
`define IFV_PRE_LAST 2'h3

// Status register field positions.
`define IFV_B_ST_REQ 8
`define IFV_B_ST_FULL 9

// Edge detector lanes and fixed edge codes.
`define IFV_EDGE_N 6
`define IFV_LANE_EXT1 3
`define IFV_LANE_CMP0 4
`define IFV_LANE_TBCLK 5
`define IFV_EDGE_BOTH 2'h3
`define IFV_EDGE_RISE 2'h1

// Source count and vector addresses, index 0 has the highest priority.
`define IFV_NSRC 5
`define IFV_VEC_HALL 8'h04
`define IFV_VEC_EXT1 8'h08
`define IFV_VEC_CMP0 8'h0c
`define IFV_VEC_TBASE 8'h10
`define IFV_VEC_MF 8'h14

`endif

// File: common/ifv_pkg.sv
// Types shared by the interrupt flag, vectoring and time base block.
`include "ifv_consts.svh"
package ifv_pkg;
   // State of the edge detector: two synchroniser stages, history, event.
   typedef struct packed {
      logic [`IFV_EDGE_N-1:0] s1;
      logic [`IFV_EDGE_N-1:0] s2;
      logic [`IFV_EDGE_N-1:0] s3;
      logic [`IFV_EDGE_N-1:0] evt;
   } ifv_edge_state_t;

   // State of the controller.
   typedef struct packed {
      logic global_irq_enable;
      logic hall_group_flag;
      logic hall_group_en;
      logic ext1_flag;
      logic ext1_en;
      logic cmp0_flag;
      logic cmp0_en;
      logic tbase_flag;
      logic tbase_en;
      logic multifunc_group_flag;
      logic multifunc_group_en;
      logic [2:0] hall_flag;
      logic [2:0] hall_en;
      logic [5:0] hall_edge_sel;
      logic [1:0] ext1_edge_sel;
      logic tmr2_match_a_flag;
      logic tmr2_match_p_flag;
      logic tmr2_match_a_en;
      logic tmr2_match_p_en;
      logic tbase_on;
      logic tbase_clk_sel;
      logic [1:0] tbase_period_sel;
      logic [14:0] tb_cnt;
      logic [1:0] pre;
      logic [31:0] prdata;
      logic [7:0] vector;
      logic push;
      logic load;
      logic pop;
      logic wake;
   } ifv_state_t;
endpackage

// File: core/ifv_edge_det.sv
// Pin synchroniser and selectable edge detector for the event inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ifv_consts.svh"
module ifv_edge_det (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`IFV_EDGE_N-1:0] pin,
   input wire logic [2*`IFV_EDGE_N-1:0] sel,
   output logic [`IFV_EDGE_N-1:0] evt
);
   import ifv_pkg::*;

   // Current and next state.
   ifv_edge_state_t s;
   ifv_edge_state_t next_s;
   // Per-lane edge match, read from the second stage onward only.
   logic [`IFV_EDGE_N-1:0] hit;

   // Each lane: code bit 0 selects rising, bit 1 selects falling edges.
   genvar i;
   generate
      for (i = 0; i < `IFV_EDGE_N; i = i + 1) begin : g_lane
         assign hit[i] = (sel[2*i] & s.s2[i] & ~s.s3[i]) |
                         (sel[2*i+1] & ~s.s2[i] & s.s3[i]);
      end
   endgenerate

   // Shift the pins through two stages before any edge logic looks at them.
   always_comb begin
      next_s = s;
      next_s.s1 = pin;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.evt = hit;
   end

   // Register the whole state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign evt = s.evt;
endmodule // ifv_edge_det
`default_nettype wire

// File: test/ifv_core_model.sv
// Behavioural model of the core: program counter stack and return handling.
`timescale 1ns/1ps
`default_nettype none
module ifv_core_model #(
   parameter int DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic force_full,
   input wire logic ret_req,
   input wire logic slow,
   output logic instr_boundary,
   output logic stack_full,
   output logic return_from_irq
);
   logic [3:0] depth;
   logic [1:0] ph;
   // A slow core offers an accept point only every fourth cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth <= '0;
         ph <= '0;
         instr_boundary <= 1'b0;
         return_from_irq <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         instr_boundary <= !slow || ph == 2'h3;
         return_from_irq <= ret_req && depth != 4'h0;
         depth <= depth + 4'(stack_push) - 4'(stack_pop);
      end
   end
   // The full flag can also be forced to hold an accept back.
   assign stack_full = force_full || depth == 4'(DEPTH);
endmodule // ifv_core_model
`default_nettype wire

// File: test/ifv_monitor.sv
// Port checker for the interrupt flag and vectoring block.
`timescale 1ns/1ps
`default_nettype none
`include "ifv_consts.svh"
module ifv_monitor #(
   parameter int TB_BASE = 4096
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic hall_in_a,
   input wire logic hall_in_b,
   input wire logic hall_in_c,
   input wire logic ext1_pin,
   input wire logic ext1_pull_sel,
   input wire logic ext1_pull_en,
   input wire logic cmp0_out,
   input wire logic tbase_src_clk,
   input wire logic tmr2_match_a,
   input wire logic tmr2_match_p,
   input wire logic stack_full,
   input wire logic instr_boundary,
   input wire logic return_from_irq,
   input wire logic irq_req,
   input wire logic stack_push,
   input wire logic pc_load,
   input wire logic [7:0] pc_vector,
   input wire logic stack_pop,
   input wire logic wake_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_entry_push: assert property (irq_req && instr_boundary |=> stack_push && pc_load)
      else $error("accept without push");
   a_push_cause: assert property (stack_push |-> $past(irq_req) && $past(instr_boundary))
      else $error("push without accept");
   a_vector_load: assert property ($changed(pc_vector) |-> pc_load)
      else $error("vector moved without load");
   a_entry_mask: assert property (irq_req && instr_boundary |=> !irq_req)
      else $error("request kept after entry");
   a_push_once: assert property (stack_push |=> !stack_push)
      else $error("nested push");
   a_full_block: assert property (stack_full |-> !irq_req)
      else $error("request while stack full");
   a_ret_pop: assert property (return_from_irq |=> stack_pop)
      else $error("return without pop");
   a_pop_cause: assert property (stack_pop |-> $past(return_from_irq))
      else $error("pop without return");
   a_pull_keep: assert property (ext1_pull_en == ext1_pull_sel)
      else $error("pull select lost");
   a_tmr2_zero: assert property (psel && penable && !pwrite && paddr == `IFV_OFF_TMR2 |->
      prdata[31:6] == '0 && prdata[3:2] == 2'h0)
      else $error("unused timer bits not zero");
   c_push: cover property (stack_push);
   c_pop: cover property (stack_pop);
   c_wake: cover property (wake_req);
   c_err: cover property (pslverr);
endmodule // ifv_monitor
bind ifv_irq_ctrl ifv_monitor #(.TB_BASE(TB_BASE)) u_mon (.*);
`default_nettype wire

// File: test/tb_irq_flags_vectoring_and_time_base.sv
// Self-checking bench for the interrupt flag, vectoring and time base block.
`timescale 1ns/1ps
`default_nettype none
`include "ifv_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_irq_flags_vectoring_and_time_base;
   localparam int TB = 4;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = '0, pc_vector;
   logic [31:0] pwdata = '0, prdata, r, seed = 32'h7ef6b91b;
   logic hall_in_a = 0, hall_in_b = 0, hall_in_c = 0, ext1_pin = 0, ext1_pull_sel = 0;
   logic cmp0_out = 0, tbase_src_clk = 0, tmr2_match_a = 0, tmr2_match_p = 0;
   logic force_full = 0, ret_req = 0, slow = 0, err;
   logic pready, pslverr, ext1_pull_en, stack_full, instr_boundary, return_from_irq;
   logic irq_req, stack_push, pc_load, stack_pop, wake_req;
   logic [1:0] tcnt = '0;
   int miscompares = 0, comparisons = 0, cyc = 0, t0, p;
   ifv_irq_ctrl #(.TB_BASE(TB)) u_dut (.*);
   ifv_core_model u_core (.*);
   initial forever #2 pclk = ~pclk;
   // Dedicated time base clock rises every fourth cycle; free cycle count for periods.
   always @(posedge pclk) begin
      tcnt <= tcnt + 2'h1;
      tbase_src_clk <= tcnt[1];
      cyc <= cyc + 1;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // One APB transfer; the idle edge first keeps back-to-back calls clean.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      `CHK("register read", e, r)
   endtask
   // Waits for a vector load, checks it, then returns from the handler.
   task automatic serve(input logic [7:0] v);
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (k < 50 && pc_load !== 1'b1);
      `CHK("load", 1'b1, pc_load)
      `CHK("vector", v, pc_vector)
      @(posedge pclk);
      ret_req <= 1'b1;
      @(posedge pclk);
      ret_req <= 1'b0;
   endtask
   task automatic quiet;
      int n;
      n = 0;
      repeat (20) begin
         @(negedge pclk);
         if (pc_load !== 1'b0) n++;
      end
      `CHK("idle load", 0, n)
   endtask
   task automatic wake_wait;
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (k < 2000 && wake_req !== 1'b1);
      `CHK("wake", 1'b1, wake_req)
   endtask
   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // The longest period loop needs a few hundred cycles; this bound is generous.
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`IFV_OFF_TBASE, 32'h30);
      rdc(`IFV_OFF_TMR2, 32'h0);
      apb(1'b0, 8'h18, '0);
      `CHK("unmapped error", 1'b1, err)
      $display("done: reset and map");
      for (int k = 0; k < 5; k++) begin
         seed = lfsr(seed);
         ext1_pull_sel <= seed[9];
         wr(`IFV_OFF_TMR2, k == 0 ? '1 : seed);
         rdc(`IFV_OFF_TMR2, (k == 0 ? '1 : seed) & 32'h33);
      end
      wr(`IFV_OFF_TMR2, 32'h2);
      tmr2_match_a <= 1'b1;
      tmr2_match_p <= 1'b1;
      @(posedge pclk);
      tmr2_match_a <= 1'b0;
      tmr2_match_p <= 1'b0;
      rdc(`IFV_OFF_TMR2, 32'h32);
      rdc(`IFV_OFF_CTRL1, 32'h20);
      $display("done: timer flags");
      wr(`IFV_OFF_CTRL1, 32'h22);
      wr(`IFV_OFF_CTRL0, 32'h6c);
      quiet();
      wr(`IFV_OFF_CTRL0, 32'h6d);
      serve(`IFV_VEC_EXT1);
      rdc(`IFV_OFF_CTRL0, 32'h4c);
      wr(`IFV_OFF_CTRL0, 32'h4d);
      serve(`IFV_VEC_CMP0);
      wr(`IFV_OFF_CTRL0, 32'h0d);
      serve(`IFV_VEC_MF);
      rdc(`IFV_OFF_CTRL1, 32'h02);
      rdc(`IFV_OFF_TMR2, 32'h32);
      wr(`IFV_OFF_TMR2, 32'h0);
      force_full <= 1'b1;
      wr(`IFV_OFF_CTRL1, 32'h11);
      wr(`IFV_OFF_CTRL0, 32'h01);
      quiet();
      @(posedge pclk);
      force_full <= 1'b0;
      serve(`IFV_VEC_TBASE);
      rdc(`IFV_OFF_CTRL1, 32'h01);
      rdc(`IFV_OFF_STATUS, 32'h10);
      $display("done: vectoring");
      slow <= 1'b1;
      wr(`IFV_OFF_HALL, 32'h3901);
      {hall_in_a, hall_in_b, hall_in_c} <= 3'h7;
      repeat (6) @(posedge pclk);
      rdc(`IFV_OFF_HALL, 32'h3951);
      {hall_in_a, hall_in_b, hall_in_c} <= 3'h0;
      repeat (6) @(posedge pclk);
      rdc(`IFV_OFF_HALL, 32'h3971);
      rdc(`IFV_OFF_CTRL0, 32'h10);
      wr(`IFV_OFF_CTRL0, 32'h13);
      serve(`IFV_VEC_HALL);
      rdc(`IFV_OFF_CTRL0, 32'h02);
      rdc(`IFV_OFF_HALL, 32'h3971);
      wr(`IFV_OFF_HALL, 32'h4000);
      wr(`IFV_OFF_CTRL0, 32'h0);
      ext1_pin <= 1'b1;
      cmp0_out <= 1'b1;
      repeat (6) @(posedge pclk);
      rdc(`IFV_OFF_CTRL0, 32'h60);
      wr(`IFV_OFF_CTRL0, 32'h0);
      cmp0_out <= 1'b0;
      repeat (6) @(posedge pclk);
      rdc(`IFV_OFF_CTRL0, 32'h40);
      wr(`IFV_OFF_CTRL0, 32'h0);
      $display("done: pin events");
      for (int i = 0; i < 5; i++) begin
         p = (i < 4) ? i : 1;
         wr(`IFV_OFF_TBASE, 32'h0);
         wr(`IFV_OFF_CTRL1, 32'h0);
         wr(`IFV_OFF_TBASE, (i < 4) ? (32'hc0 | (i << 4)) : 32'h90);
         wake_wait();
         t0 = cyc;
         wr(`IFV_OFF_CTRL1, 32'h0);
         wake_wait();
         `CHK("period", 4 * (TB << p), cyc - t0)
      end
      wr(`IFV_OFF_TBASE, 32'h0);
      $display("done: time base");
      print_verdict();
   end
endmodule // tb_irq_flags_vectoring_and_time_base
`default_nettype wire
